// ---- src/agb_pkg.sv ----
package agb_pkg;

  // address mode selection
  typedef enum logic [2:0] {
    MODE_ABS_FIRST  = 3'b000,
    MODE_ABS_SECOND = 3'b001,
    MODE_IND_IDX    = 3'b010,
    MODE_IDX_IND    = 3'b011,
    MODE_ZP         = 3'b100,
    MODE_ZP_FIRST   = 3'b101,
    MODE_ZP_SECOND  = 3'b110
  } addr_mode_e;

  // instruction operations on the index/flag datapath
  typedef enum logic [3:0] {
    OP_NONE                   = 4'h0,
    OP_INCREMENT_FIRST_INDEX  = 4'h1,
    OP_DECREMENT_FIRST_INDEX  = 4'h2,
    OP_INCREMENT_SECOND_INDEX = 4'h3,
    OP_DECREMENT_SECOND_INDEX = 4'h4,
    OP_COMPARE_FIRST_INDEX    = 4'h5,
    OP_COMPARE_SECOND_INDEX   = 4'h6,
    OP_LOAD_ACCUMULATOR       = 4'h7,
    OP_LOAD_FIRST_INDEX       = 4'h8,
    OP_LOAD_SECOND_INDEX      = 4'h9,
    OP_BRANCH_IF_ZERO_SET     = 4'hA,
    OP_BRANCH_IF_ZERO_CLEAR   = 4'hB
  } exec_op_e;

  typedef enum logic [1:0] {
    AG_IDLE = 2'b00,
    AG_PTR_LOW = 2'b01,
    AG_PTR_HIGH = 2'b10,
    AG_DONE = 2'b11
  } ag_state_e;

  typedef struct packed {
    addr_mode_e mode;
    logic [15:0] operand;
  } addr_req_s;

  typedef struct packed {
    exec_op_e op;
    logic [7:0] value;
  } exec_req_s;

  localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] EA_RESET = 16'h0000;

endpackage : agb_pkg

// ---- src/index_unit.sv ----
`timescale 1ns/100ps
// one index register with load, wrapping step and compare
module index_unit
  import agb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic inc,
  input wire logic dec,
  input wire logic [7:0] load_value,
  input wire logic [7:0] cmp_value,
  // results
  output logic [7:0] value,
  output logic [7:0] step_result,
  output logic cmp_equal
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  // 8-bit add and subtract drop the carry, so ff wraps to 00 and 00 to ff
  assign step_result = inc ? value_reg + 8'h01 : value_reg - 8'h01;
  assign value_next = load ? load_value : ((inc || dec) ? step_result : value_reg);
  assign cmp_equal = (value_reg == cmp_value);
  assign value = value_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      value_reg <= BYTE_ZERO;
    else
      value_reg <= value_next;
  end

endmodule // index_unit

// ---- src/cpu_address_gen_branch.sv ----
`timescale 1ns/100ps
module cpu_address_gen_branch
  import agb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // address request
  input wire logic addr_start,
  input wire addr_req_s addr_req,
  output logic addr_busy,
  output logic addr_valid,
  output logic [15:0] effective_addr,
  // pointer fetch from memory
  output logic mem_read,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  // execution request
  input wire logic exec_start,
  input wire exec_req_s exec_req,
  input wire logic [15:0] next_pc,
  output logic [15:0] pc,
  output logic branch_taken,
  // state
  output logic zero_flag,
  output logic [7:0] first_index,
  output logic [7:0] second_index,
  output logic [7:0] accumulator
);

  ag_state_e state_reg, state_next;
  addr_mode_e mode_reg;
  logic [7:0] zp_ptr_reg;
  logic [7:0] ptr_low_reg;
  logic [15:0] ea_reg;
  logic [15:0] ea_next;
  logic [15:0] pc_reg;
  logic zero_reg;
  logic taken_reg;
  logic [7:0] acc_reg;

  // index registers
  logic x_load, x_inc, x_dec, y_load, y_inc, y_dec;
  logic [7:0] x_val, y_val, x_step, y_step;
  logic x_eq, y_eq;

  wire logic exec_go = exec_start;
  wire exec_op_e op = exec_req.op;
  assign x_load = exec_go && (op == OP_LOAD_FIRST_INDEX);
  assign x_inc = exec_go && (op == OP_INCREMENT_FIRST_INDEX);
  assign x_dec = exec_go && (op == OP_DECREMENT_FIRST_INDEX);
  assign y_load = exec_go && (op == OP_LOAD_SECOND_INDEX);
  assign y_inc = exec_go && (op == OP_INCREMENT_SECOND_INDEX);
  assign y_dec = exec_go && (op == OP_DECREMENT_SECOND_INDEX);

  index_unit u_first
  (
    .clock(clock),
    .rst_n(rst_n),
    .load(x_load),
    .inc(x_inc),
    .dec(x_dec),
    .load_value(exec_req.value),
    .cmp_value(exec_req.value),
    .value(x_val),
    .step_result(x_step),
    .cmp_equal(x_eq)
  );

  index_unit u_second
  (
    .clock(clock),
    .rst_n(rst_n),
    .load(y_load),
    .inc(y_inc),
    .dec(y_dec),
    .load_value(exec_req.value),
    .cmp_value(exec_req.value),
    .value(y_val),
    .step_result(y_step),
    .cmp_equal(y_eq)
  );

  // address generation
  wire addr_req_s req = addr_req;
  wire logic [15:0] abs_x_sum = req.operand + {8'h00, x_val};
  wire logic [15:0] abs_y_sum = req.operand + {8'h00, y_val};
  wire logic [7:0] zp_x_sum = req.operand[7:0] + x_val;
  wire logic [7:0] zp_y_sum = req.operand[7:0] + y_val;
  wire logic is_ptr_mode = (req.mode == MODE_IND_IDX) || (req.mode == MODE_IDX_IND);
  wire logic [7:0] ptr_start = (req.mode == MODE_IDX_IND) ? zp_x_sum : req.operand[7:0];
  wire logic [7:0] ptr_second = zp_ptr_reg + 8'h01;
  wire logic [15:0] ptr_full = {mem_rdata, ptr_low_reg};
  wire logic [15:0] ind_y_sum = ptr_full + {8'h00, y_val};

  logic [15:0] direct_ea;
  always_comb
  begin
    case (req.mode)
      MODE_ABS_FIRST: direct_ea = abs_x_sum;
      MODE_ABS_SECOND: direct_ea = abs_y_sum;
      MODE_ZP: direct_ea = {ZERO_PAGE_HIGH, req.operand[7:0]};
      MODE_ZP_FIRST: direct_ea = {ZERO_PAGE_HIGH, zp_x_sum};
      MODE_ZP_SECOND: direct_ea = {ZERO_PAGE_HIGH, zp_y_sum};
      default: direct_ea = req.operand;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    ea_next = ea_reg;
    case (state_reg)
      AG_IDLE, AG_DONE:
      begin
        if (addr_start && is_ptr_mode)
          state_next = AG_PTR_LOW;
        else if (addr_start)
        begin
          state_next = AG_DONE;
          ea_next = direct_ea;
        end
        else
          state_next = AG_IDLE;
      end
      AG_PTR_LOW:
        if (mem_rvalid)
          state_next = AG_PTR_HIGH;
      AG_PTR_HIGH:
        if (mem_rvalid)
        begin
          state_next = AG_DONE;
          ea_next = (mode_reg == MODE_IND_IDX) ? ind_y_sum : ptr_full;
        end
      default: state_next = AG_IDLE;
    endcase
  end

  wire logic accept = addr_start && ((state_reg == AG_IDLE) || (state_reg == AG_DONE));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= AG_IDLE;
      mode_reg <= MODE_ZP;
      zp_ptr_reg <= BYTE_ZERO;
      ptr_low_reg <= BYTE_ZERO;
      ea_reg <= EA_RESET;
    end
    else
    begin
      state_reg <= state_next;
      ea_reg <= ea_next;
      if (accept)
      begin
        mode_reg <= req.mode;
        zp_ptr_reg <= ptr_start;
      end
      if (state_reg == AG_PTR_LOW && mem_rvalid)
      begin
        ptr_low_reg <= mem_rdata;
        zp_ptr_reg <= ptr_second;
      end
    end
  end

  assign addr_busy = (state_reg == AG_PTR_LOW) || (state_reg == AG_PTR_HIGH);
  assign addr_valid = (state_reg == AG_DONE);
  assign effective_addr = ea_reg;
  assign mem_read = addr_busy;
  assign mem_addr = {ZERO_PAGE_HIGH, zp_ptr_reg};

  // flag, accumulator and branch
  logic zero_next;
  always_comb
  begin
    zero_next = zero_reg;
    if (exec_go)
    begin
      case (op)
        OP_INCREMENT_FIRST_INDEX, OP_DECREMENT_FIRST_INDEX: zero_next = ~|x_step;
        OP_INCREMENT_SECOND_INDEX, OP_DECREMENT_SECOND_INDEX: zero_next = ~|y_step;
        OP_COMPARE_FIRST_INDEX: zero_next = x_eq;
        OP_COMPARE_SECOND_INDEX: zero_next = y_eq;
        OP_LOAD_ACCUMULATOR, OP_LOAD_FIRST_INDEX, OP_LOAD_SECOND_INDEX:
          zero_next = (exec_req.value == BYTE_ZERO);
        default: zero_next = zero_reg;
      endcase
    end
  end

  wire logic is_branch = exec_go && (op inside {OP_BRANCH_IF_ZERO_SET, OP_BRANCH_IF_ZERO_CLEAR});
  wire logic take = is_branch && ((op == OP_BRANCH_IF_ZERO_SET) == zero_reg);
  wire logic [15:0] offset_ext = {{8{exec_req.value[7]}}, exec_req.value};
  wire logic [15:0] branch_target = next_pc + offset_ext;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_reg <= 1'b0;
      pc_reg <= PC_RESET;
      taken_reg <= 1'b0;
      acc_reg <= BYTE_ZERO;
    end
    else
    begin
      zero_reg <= zero_next;
      taken_reg <= take;
      if (is_branch)
        pc_reg <= take ? branch_target : next_pc;
      if (exec_go && op == OP_LOAD_ACCUMULATOR)
        acc_reg <= exec_req.value;
    end
  end

  assign pc = pc_reg;
  assign branch_taken = taken_reg;
  assign zero_flag = zero_reg;
  assign first_index = x_val;
  assign second_index = y_val;
  assign accumulator = acc_reg;

  property p_wrap_first;
    @(posedge clock) disable iff (!rst_n)
    (exec_go && op == OP_INCREMENT_FIRST_INDEX && x_val == BYTE_MAX) |=> (x_val == BYTE_ZERO);
  endproperty
  a_wrap_first: assert property (p_wrap_first) else $error("first index no wrap");

  property p_dec_wrap;
    @(posedge clock) disable iff (!rst_n)
    (exec_go && op == OP_DECREMENT_SECOND_INDEX && y_val == BYTE_ZERO)
      |=> (y_val == BYTE_MAX && !zero_flag);
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("second index no wrap");

  property p_zero_load;
    @(posedge clock) disable iff (!rst_n)
    (exec_go && op == OP_LOAD_ACCUMULATOR) |=> (zero_flag == ($past(exec_req.value) == 8'h00));
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("zero flag wrong");

  property p_compare;
    @(posedge clock) disable iff (!rst_n)
    (exec_go && op == OP_COMPARE_FIRST_INDEX)
      |=> (zero_flag == ($past(x_val) == $past(exec_req.value)));
  endproperty
  a_compare: assert property (p_compare) else $error("compare flag wrong");

  property p_not_taken;
    @(posedge clock) disable iff (!rst_n)
    (is_branch && !take) |=> (pc == $past(next_pc) && !branch_taken && $stable(zero_flag));
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch moved");

  property p_branch_range;
    @(posedge clock) disable iff (!rst_n)
    take |=> (branch_taken && (pc - $past(next_pc) + 16'h0080 <= 16'h00FF));
  endproperty
  a_branch_range: assert property (p_branch_range) else $error("branch out of range");

  property p_zp_fetch;
    @(posedge clock) disable iff (!rst_n)
    (state_reg == AG_PTR_HIGH && $past(state_reg) == AG_PTR_LOW)
      |-> (mem_addr == {8'h00, $past(mem_addr[7:0]) + 8'h01});
  endproperty
  a_zp_fetch: assert property (p_zp_fetch) else $error("pointer fetch off page zero");

  property p_ind_idx;
    @(posedge clock) disable iff (!rst_n)
    (state_reg == AG_PTR_HIGH && mem_rvalid && mode_reg == MODE_IND_IDX)
      |=> (effective_addr == $past(ptr_full) + {8'h00, $past(y_val)});
  endproperty
  a_ind_idx: assert property (p_ind_idx) else $error("indirect indexed wrong");

  property p_abs_idx;
    @(posedge clock) disable iff (!rst_n)
    (accept && req.mode == MODE_ABS_FIRST)
      |=> (addr_valid && effective_addr == $past(req.operand) + {8'h00, $past(x_val)});
  endproperty
  a_abs_idx: assert property (p_abs_idx) else $error("absolute indexed wrong");

endmodule // cpu_address_gen_branch

// ---- testbench/zp_memory_model.sv ----
`timescale 1ns/100ps
// zero-page memory answering each pointer byte after a chosen lag
module zp_memory_model
(
  // clock
  input wire logic clock,
  // read port
  input wire logic mem_read,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  // answer lag in cycles
  input wire logic [3:0] lag
);
  logic [7:0] store [256];
  logic [3:0] wait_reg;
  initial
  begin
    mem_rdata = 8'h00;
    mem_rvalid = 1'b0;
    wait_reg = 4'h0;
  end
  always @(posedge clock)
  begin
    if (mem_rvalid)
    begin
      // released data shows the inverse of the last byte
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg <= 4'h0;
    end
    else if (mem_read && wait_reg >= lag)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata <= store[mem_addr[7:0]];
    end
    else if (mem_read)
      wait_reg <= wait_reg + 4'h1;
  end
endmodule // zp_memory_model

// ---- testbench/test_cpu_address_gen_branch.sv ----
`timescale 1ns/100ps
module test_cpu_address_gen_branch;
  import agb_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic addr_start = 1'b0;
  addr_req_s addr_req = '0;
  logic exec_start = 1'b0;
  exec_req_s exec_req = '0;
  logic [15:0] next_pc = 16'h0000;
  logic [3:0] lag = 4'h0;
  logic addr_busy, addr_valid, mem_read, mem_rvalid, branch_taken, zero_flag;
  logic [15:0] effective_addr, mem_addr, pc, b, t;
  logic [7:0] mem_rdata, first_index, second_index, accumulator;
  logic [7:0] x, y, p, lo, hi, v, o;
  logic [31:0] seed = 32'h0000A15F;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int i, k;

  cpu_address_gen_branch DUT (.clock(clock), .rst_n(rst_n), .addr_start(addr_start),
    .addr_req(addr_req), .addr_busy(addr_busy), .addr_valid(addr_valid),
    .effective_addr(effective_addr), .mem_read(mem_read), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .exec_start(exec_start),
    .exec_req(exec_req), .next_pc(next_pc), .pc(pc), .branch_taken(branch_taken),
    .zero_flag(zero_flag), .first_index(first_index), .second_index(second_index),
    .accumulator(accumulator));
  zp_memory_model mem_u (.clock(clock), .mem_read(mem_read), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .lag(lag));

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
    return seed[15:8] ^ seed[7:0];
  endfunction

  function automatic logic [15:0] br_target(input logic [15:0] npc, input logic [7:0] off);
    return npc + {{8{off[7]}}, off};
  endfunction

  task automatic close_out();
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op_go(input exec_op_e op, input logic [7:0] val, input logic [15:0] npc);
    @(posedge clock);
    #1;
    exec_start = 1'b1;
    exec_req = '{op, val};
    next_pc = npc;
    @(posedge clock);
    #1;
    exec_start = 1'b0;
  endtask

  task automatic ad_go(input addr_mode_e m, input logic [15:0] opd, input logic [15:0] exp);
    logic [7:0] r;
    logic [15:0] cyc;
    int n;
    r = rnd();
    @(posedge clock);
    #1;
    lag = {2'b00, r[1:0]};
    addr_start = 1'b1;
    addr_req = '{m, opd};
    @(posedge clock);
    #1;
    addr_start = 1'b0;
    n = 0;
    while (!(addr_valid === 1'b1 && addr_busy === 1'b0) && n < 40)
    begin
      if (mem_read === 1'b1)
        chk({8'h00, mem_addr[15:8]}, 16'h0000);
      @(posedge clock);
      #1;
      n = n + 1;
    end
    // pointer modes wait for two memory answers of lag plus two cycles each
    cyc = (m == MODE_IND_IDX || m == MODE_IDX_IND) ? {11'h000, lag, 1'b0} + 16'h0004 : 16'h0000;
    chk({14'h0000, addr_valid, addr_busy}, 16'h0002);
    chk(16'(n), cyc);
    chk(effective_addr, exp);
  endtask

  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      close_out();
    end
  end

  initial
  begin
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk(pc, PC_RESET);
    for (i = 0; i < 24; i++)
    begin
      x = rnd();
      y = rnd();
      p = rnd();
      lo = rnd();
      hi = rnd();
      b = {rnd(), rnd()};
      if (i == 0)
      begin
        p = 8'hFF;
        b[7:0] = 8'hFF;
      end
      op_go(OP_LOAD_FIRST_INDEX, x, b);
      op_go(OP_LOAD_SECOND_INDEX, y, b);
      chk({first_index, second_index}, {x, y});
      ad_go(MODE_ABS_FIRST, b, b + {8'h00, x});
      ad_go(MODE_ABS_SECOND, b, b + {8'h00, y});
      ad_go(MODE_ZP, b, {8'h00, b[7:0]});
      ad_go(MODE_ZP_FIRST, b, {8'h00, b[7:0] + x});
      ad_go(MODE_ZP_SECOND, b, {8'h00, b[7:0] + y});
      mem_u.store[p] = lo;
      mem_u.store[p + 8'h01] = hi;
      ad_go(MODE_IND_IDX, {8'h00, p}, {hi, lo} + {8'h00, y});
      v = p - x;
      ad_go(MODE_IDX_IND, {8'h00, v}, {hi, lo});
    end
    for (k = 0; k < 4; k++)
    begin
      v = k[0] ? 8'h00 : 8'hFF;
      op_go(k < 2 ? OP_LOAD_FIRST_INDEX : OP_LOAD_SECOND_INDEX, v, 16'h0000);
      op_go(exec_op_e'(4'(k + 1)), 8'h00, 16'h0000);
      chk({8'h00, k < 2 ? first_index : second_index}, {8'h00, ~v});
      chk({15'h0000, zero_flag}, {15'h0000, v == 8'hFF});
    end
    for (k = 0; k < 8; k++)
    begin
      v = 8'h40 ^ (rnd() | 8'h01);
      b = {rnd(), rnd()};
      o = k[2] ? 8'h80 : 8'h7F;
      op_go(OP_LOAD_ACCUMULATOR, k[0] ? 8'h00 : v, b);
      chk({accumulator, 7'h00, zero_flag}, {k[0] ? 8'h00 : v, 7'h00, k[0]});
      op_go(k[2] ? OP_LOAD_SECOND_INDEX : OP_LOAD_FIRST_INDEX, 8'h40, b);
      op_go(k[2] ? OP_COMPARE_SECOND_INDEX : OP_COMPARE_FIRST_INDEX, k[1] ? 8'h40 : v, b);
      chk({15'h0000, zero_flag}, {15'h0000, k[1]});
      op_go(k[0] ? OP_BRANCH_IF_ZERO_SET : OP_BRANCH_IF_ZERO_CLEAR, o, b);
      t = (k[1] == k[0]) ? br_target(b, o) : b;
      chk(pc, t);
      chk({15'h0000, branch_taken}, {15'h0000, k[1] == k[0]});
      @(posedge clock);
      #1;
      chk({15'h0000, branch_taken}, 16'h0000);
    end
    close_out();
  end
endmodule // test_cpu_address_gen_branch
